// *** verif/cbm_bit_timing_mask_props.sv ***
`timescale 1ns/1ns
module cbm_bit_timing_mask_props (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic rx_buffer_event_i,
	input wire logic tx_buffer_event_i,
	input wire logic match_request_i,
	input wire logic match_valid_o,
	input wire logic match_accept_o,
	input wire logic bit_start_o,
	input wire logic sample_point_o,
	input wire logic rx_bit_o,
	input wire logic rx_buffer_irq_flag_o,
	input wire logic tx_buffer_irq_flag_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	property p_mreq;
		match_request_i |=> match_valid_o;
	endproperty
	a_mreq: assert property (p_mreq) else $error("match answer missing");
	property p_mvld;
		match_valid_o |-> $past(match_request_i);
	endproperty
	a_mvld: assert property (p_mvld) else $error("match answer unasked");
	property p_macc;
		!match_request_i |=> $stable(match_accept_o);
	endproperty
	a_macc: assert property (p_macc) else $error("accept moved alone");
	property p_rxset;
		rx_buffer_event_i |=> rx_buffer_irq_flag_o;
	endproperty
	a_rxset: assert property (p_rxset) else $error("rx flag not set");
	property p_rxrise;
		$rose(rx_buffer_irq_flag_o) |-> $past(rx_buffer_event_i);
	endproperty
	a_rxrise: assert property (p_rxrise) else $error("rx flag set alone");
	property p_txset;
		tx_buffer_event_i |=> tx_buffer_irq_flag_o;
	endproperty
	a_txset: assert property (p_txset) else $error("tx flag not set");
	property p_txrise;
		$rose(tx_buffer_irq_flag_o) |-> $past(tx_buffer_event_i);
	endproperty
	a_txrise: assert property (p_txrise) else $error("tx flag set alone");
	property p_spbs;
		sample_point_o |=> !bit_start_o;
	endproperty
	a_spbs: assert property (p_spbs) else $error("phase two too short");
	property p_bssp;
		bit_start_o |=> !sample_point_o [*4];
	endproperty
	a_bssp: assert property (p_bssp) else $error("sample point too early");
	property p_rxbit;
		$changed(rx_bit_o) |-> sample_point_o;
	endproperty
	a_rxbit: assert property (p_rxbit) else $error("bit moved off sample");
	c_acc: cover property (match_valid_o && match_accept_o);
	c_zero: cover property (sample_point_o ##1 !rx_bit_o);
	c_flag: cover property ($rose(tx_buffer_irq_flag_o));
endmodule // cbm_bit_timing_mask_props

// *** verif/cbm_can_node.sv ***
`timescale 1ns/1ns
module cbm_can_node (
	input wire logic clk_sys_i,
	output logic can_rx_o
);
	// The line idles recessive through the transceiver pull-up.
	initial can_rx_o = 1'h1;
	task automatic hold_low(input int n);
		@(posedge clk_sys_i);
		can_rx_o <= 1'h0;
		repeat (n) @(posedge clk_sys_i);
		can_rx_o <= 1'h1;
	endtask
endmodule // cbm_can_node

// *** verif/cbm_testbench.sv ***
`timescale 1ns/1ns
module testbench;
	import cbm_pkg::*;
	logic clk_sys_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, can_rx_i;
	logic rx_buffer_event_i, tx_buffer_event_i, match_request_i, msg_extended_i;
	logic filter_extended_enable_i, match_valid_o, match_accept_o, bit_start_o;
	logic sample_point_o, rx_bit_o, wakeup_o, rx_buffer_irq_flag_o, tx_buffer_irq_flag_o;
	logic [ADDR_W-1:0] avs_address_i;
	logic [DATA_W-1:0] avs_writedata_i, avs_readdata_o;
	logic [BE_W-1:0] avs_byteenable_i;
	logic [ID_W-1:0] msg_id_i, filter_id_i;
	logic [FILT_IDX_W-1:0] filter_index_i;
	logic seen;
	int fails, cmp_count;
	cbm_bit_timing_mask dut_u (.clk_sys_i, .rst_n_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
		.avs_waitrequest_o, .can_rx_i, .rx_buffer_event_i, .tx_buffer_event_i,
		.match_request_i, .msg_id_i, .msg_extended_i, .filter_index_i, .filter_id_i,
		.filter_extended_enable_i, .match_valid_o, .match_accept_o, .bit_start_o,
		.sample_point_o, .rx_bit_o, .wakeup_o, .rx_buffer_irq_flag_o, .tx_buffer_irq_flag_o);
	cbm_can_node node_u (.clk_sys_i, .can_rx_o(can_rx_i));
	initial begin
		clk_sys_i = 1'h0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) if (wakeup_o === 1'h1) seen <= 1'h1;
	initial begin
		#2000000;
		fails++;
		finish_test();
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic acc(input logic [5:0] a, input logic [15:0] d, input logic w,
		output logic [31:0] q);
		@(posedge clk_sys_i);
		avs_address_i <= a;
		avs_writedata_i <= {16'h0, d};
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'h0);
		q = avs_readdata_o;
		avs_write_i <= 1'h0;
		avs_read_i <= 1'h0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		logic [31:0] q;
		acc(a, d, 1'h1, q);
	endtask
	task automatic rdc(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(a, 16'h0, 1'h0, q);
		chk($sformatf("reg %h", a), q, e);
	endtask
	task automatic mt(input logic [2:0] ix, input logic [28:0] m, f, input logic me, fe, ex);
		@(posedge clk_sys_i);
		match_request_i <= 1'h1;
		filter_index_i <= ix;
		msg_id_i <= m;
		filter_id_i <= f;
		msg_extended_i <= me;
		filter_extended_enable_i <= fe;
		@(posedge clk_sys_i);
		match_request_i <= 1'h0;
		@(negedge clk_sys_i);
		chk("match valid", {31'h0, match_valid_o}, 32'h1);
		chk("match accept", {31'h0, match_accept_o}, {31'h0, ex});
	endtask
	task automatic wait_sp();
		do @(posedge clk_sys_i); while (sample_point_o !== 1'h1);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int i = 0; i < 11; i++) rdc(6'(i * 4), (i == 9) ? 32'h5 : 32'h0);
	endtask
	task automatic t_flags();
		@(posedge clk_sys_i);
		rx_buffer_event_i <= 1'h1;
		@(posedge clk_sys_i);
		rx_buffer_event_i <= 1'h0;
		rdc(OFF_INTF, 32'h2);
		tx_buffer_event_i <= 1'h1;
		@(posedge clk_sys_i);
		tx_buffer_event_i <= 1'h0;
		rdc(OFF_INTF, 32'h3);
		wr(OFF_INTF, 16'h0);
		rdc(OFF_INTF, 32'h0);
	endtask
	task automatic t_timing();
		logic [15:0] cfg [4] = '{16'hffff, 16'h0038, 16'h0080, 16'h0707};
		int bt [4] = '{25, 18, 4, 12};
		int n;
		for (int i = 0; i < 4; i++) begin
			wr(OFF_CFG2, cfg[i]);
			rdc(OFF_CFG2, {16'h0, cfg[i] & 16'h47ff});
			rdc(OFF_STATUS, 32'(bt[i]));
			repeat (2) do @(posedge clk_sys_i); while (bit_start_o !== 1'h1);
			n = 0;
			do begin
				@(posedge clk_sys_i);
				n++;
			end while (bit_start_o !== 1'h1);
			chk("bit period", 32'(n), 32'(2 * bt[i]));
		end
	endtask
	task automatic t_sample();
		wr(OFF_CFG2, 16'h0000);
		wait_sp();
		repeat (4) @(posedge clk_sys_i);
		node_u.hold_low(4);
		wait_sp();
		chk("single sample", {31'h0, rx_bit_o}, 32'h0);
		wr(OFF_CFG2, 16'h0040);
		wait_sp();
		// A single low quantum must be outvoted by the two before it.
		repeat (4) @(posedge clk_sys_i);
		node_u.hold_low(2);
		wait_sp();
		chk("triple sample", {31'h0, rx_bit_o}, 32'h1);
	endtask
	task automatic t_wake();
		wr(OFF_CFG2, 16'h4000);
		seen = 1'h0;
		node_u.hold_low(4);
		repeat (4) @(posedge clk_sys_i);
		chk("wake short", {31'h0, seen}, 32'h0);
		node_u.hold_low(10);
		repeat (4) @(posedge clk_sys_i);
		chk("wake long", {31'h0, seen}, 32'h1);
		wr(OFF_CFG2, 16'h0000);
		seen = 1'h0;
		node_u.hold_low(1);
		repeat (3) @(posedge clk_sys_i);
		chk("wake unfiltered", {31'h0, seen}, 32'h1);
	endtask
	task automatic t_match();
		logic [28:0] m1 = {11'h123, 18'h0};
		logic [28:0] f2 = {11'h124, 18'h0};
		wr(OFF_FMSK, 16'hc024);
		rdc(OFF_FMSK, 32'hc024);
		wr(6'h1c, 16'hffff);
		rdc(6'h1c, 32'hffeb);
		wr(6'h0c, 16'hffe3);
		wr(6'h10, 16'hffff);
		wr(6'h1c, 16'hffe8);
		rdc(6'h0c, 32'hffe3);
		mt(3'h0, m1, f2, 1'h0, 1'h0, 1'h0);
		mt(3'h1, m1, f2, 1'h0, 1'h0, 1'h1);
		mt(3'h0, {11'h0, 18'h10000}, 29'h0, 1'h1, 1'h1, 1'h0);
		mt(3'h0, 29'h1, 29'h0, 1'h1, 1'h1, 1'h0);
		mt(3'h0, 29'h1, 29'h1, 1'h1, 1'h1, 1'h1);
		mt(3'h2, m1, m1, 1'h1, 1'h0, 1'h0);
		mt(3'h2, m1, m1, 1'h1, 1'h1, 1'h1);
		mt(3'h1, m1, f2, 1'h1, 1'h0, 1'h1);
		mt(3'h7, m1, m1, 1'h0, 1'h0, 1'h0);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n_i = 1'h0;
		avs_read_i = 1'h0;
		avs_write_i = 1'h0;
		avs_address_i = '0;
		avs_writedata_i = '0;
		avs_byteenable_i = 4'h3;
		rx_buffer_event_i = 1'h0;
		tx_buffer_event_i = 1'h0;
		match_request_i = 1'h0;
		msg_id_i = '0;
		filter_id_i = '0;
		filter_index_i = '0;
		msg_extended_i = 1'h0;
		filter_extended_enable_i = 1'h0;
		seen = 1'h0;
		fails = 0;
		cmp_count = 0;
		repeat (16) @(posedge clk_sys_i);
		rst_n_i <= 1'h1;
		t_reset();
		t_flags();
		t_timing();
		t_sample();
		t_wake();
		t_match();
		finish_test();
	end
endmodule // testbench
bind cbm_bit_timing_mask cbm_bit_timing_mask_props chk_u (.clk_sys_i, .rst_n_i,
	.rx_buffer_event_i, .tx_buffer_event_i, .match_request_i, .match_valid_o,
	.match_accept_o, .bit_start_o, .sample_point_o, .rx_bit_o, .rx_buffer_irq_flag_o,
	.tx_buffer_irq_flag_o);

// *** verilog/cbm_bit_timing_mask.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// - Propagation length is field plus one quanta.
// - Select set: use programmed second phase directly.
// - Select clear: second phase is max(phase one, INFO_PROCESSING_TIME).
// - Sample bit: three samples, else one.
// - Wake-up filter bit applies line filter.
// - Mask source codes pick masks 0, 1, 2.
// - Filters 15..8 in 2-bit slots, reset zero.
// - Eleven standard mask bits include or ignore.
// - Extended bits 17..16 include or ignore.
// - Mode set: frame type must match filter.
// - Mode clear: either frame type accepted.
// - Three independent mask sets, numbered 0..2.
// - Receive buffer event sets receive flag.
// - Transmit buffer event sets transmit flag.
// - Sixteen lower extended mask bits per set.
module cbm_bit_timing_mask (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [cbm_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [cbm_pkg::DATA_W-1:0] avs_writedata_i,
	input wire logic [cbm_pkg::BE_W-1:0] avs_byteenable_i,
	output logic [cbm_pkg::DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic can_rx_i,
	input wire logic rx_buffer_event_i,
	input wire logic tx_buffer_event_i,
	input wire logic match_request_i,
	input wire logic [cbm_pkg::ID_W-1:0] msg_id_i,
	input wire logic msg_extended_i,
	input wire logic [cbm_pkg::FILT_IDX_W-1:0] filter_index_i,
	input wire logic [cbm_pkg::ID_W-1:0] filter_id_i,
	input wire logic filter_extended_enable_i,
	output logic match_valid_o,
	output logic match_accept_o,
	output logic bit_start_o,
	output logic sample_point_o,
	output logic rx_bit_o,
	output logic wakeup_o,
	output logic rx_buffer_irq_flag_o,
	output logic tx_buffer_irq_flag_o
);
	import cbm_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Avalon slave handshake.

	logic ack;
	logic req;
	logic wr_ack;
	logic [REG_W-1:0] intf_reg;
	logic [REG_W-1:0] cfg2;
	logic [REG_W-1:0] fmsk;
	logic [REG_W-1:0] mask_sid [MASK_SETS];
	logic [REG_W-1:0] mask_eid [MASK_SETS];
	logic [BT_W-1:0] bit_time_tq;
	logic [REG_W-1:0] next_rdata;

	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~ack;
	assign wr_ack = avs_write_i & ack;

	// Every access takes one wait cycle; the answer lands at the second edge.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack <= 1'b0;
		end else begin
			ack <= req & ~ack;
		end
	end

	function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old_v,
			input logic [DATA_W-1:0] wd, input logic [BE_W-1:0] be,
			input logic [REG_W-1:0] wmask);
		logic [REG_W-1:0] lane;
		lane = {{8{be[1]}}, {8{be[0]}}} & wmask;
		merge16 = (old_v & ~lane) | (wd[REG_W-1:0] & lane);
	endfunction

	always_comb begin
		next_rdata = 16'h0000;
		case (avs_address_i)
			OFF_INTF: next_rdata = intf_reg;
			OFF_CFG2: next_rdata = cfg2;
			OFF_FMSK: next_rdata = fmsk;
			OFF_STATUS: next_rdata = {{(REG_W-BT_W){1'b0}}, bit_time_tq};
			default: begin
				for (int s = 0; s < MASK_SETS; s++) begin
					if (avs_address_i == ADDR_W'(OFF_MASK_BASE + s * MASK_STRIDE)) begin
						next_rdata = mask_sid[s];
					end
					if (avs_address_i ==
							ADDR_W'(OFF_MASK_BASE + s * MASK_STRIDE + MASK_EID_OFS)) begin
						next_rdata = mask_eid[s];
					end
				end
			end
		endcase
	end

	// Unmapped addresses read as zero; upper lanes always read as zero.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_read_i && !ack) begin
			avs_readdata_o <= {{(DATA_W-REG_W){1'b0}}, next_rdata};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers.

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg2 <= CFG2_RST;
		end else if (wr_ack && avs_address_i == OFF_CFG2) begin
			cfg2 <= merge16(cfg2, avs_writedata_i, avs_byteenable_i, CFG2_WMASK);
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fmsk <= FMSK_RST;
		end else if (wr_ack && avs_address_i == OFF_FMSK) begin
			fmsk <= merge16(fmsk, avs_writedata_i, avs_byteenable_i, 16'hffff);
		end
	end

	genvar g;
	generate
		for (g = 0; g < MASK_SETS; g++) begin : g_mask
			localparam logic [ADDR_W-1:0] SID_ADDR = ADDR_W'(OFF_MASK_BASE + g * MASK_STRIDE);
			localparam logic [ADDR_W-1:0] EID_ADDR = ADDR_W'(SID_ADDR + MASK_EID_OFS);
			// Each set is stored on its own and decoded at its own address.
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					mask_sid[g] <= MASK_RST;
				end else if (wr_ack && avs_address_i == SID_ADDR) begin
					mask_sid[g] <= merge16(mask_sid[g], avs_writedata_i, avs_byteenable_i,
						SID_WMASK);
				end
			end
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					mask_eid[g] <= MASK_RST;
				end else if (wr_ack && avs_address_i == EID_ADDR) begin
					mask_eid[g] <= merge16(mask_eid[g], avs_writedata_i, avs_byteenable_i,
						16'hffff);
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt flags. Writing 0 clears a flag, a new event in that cycle wins.

	logic clr_rx;
	logic clr_tx;

	assign clr_rx = wr_ack && avs_address_i == OFF_INTF && avs_byteenable_i[0] &&
		!avs_writedata_i[RX_FLAG_BIT];
	assign clr_tx = wr_ack && avs_address_i == OFF_INTF && avs_byteenable_i[0] &&
		!avs_writedata_i[TX_FLAG_BIT];

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			intf_reg <= INTF_RST;
		end else begin
			if (rx_buffer_event_i) begin
				intf_reg[RX_FLAG_BIT] <= 1'b1;
			end else if (clr_rx) begin
				intf_reg[RX_FLAG_BIT] <= 1'b0;
			end
			if (tx_buffer_event_i) begin
				intf_reg[TX_FLAG_BIT] <= 1'b1;
			end else if (clr_tx) begin
				intf_reg[TX_FLAG_BIT] <= 1'b0;
			end
		end
	end

	assign rx_buffer_irq_flag_o = intf_reg[RX_FLAG_BIT];
	assign tx_buffer_irq_flag_o = intf_reg[TX_FLAG_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Bit timing.

	logic [LEN_W-1:0] prop_len;
	logic [LEN_W-1:0] ph1_len;
	logic [LEN_W-1:0] ph2_prog;
	logic [LEN_W-1:0] ph2_len;
	logic [LEN_W-1:0] seg_len;
	logic [TQ_CNT_W-1:0] tq_cnt;
	logic [LEN_W-1:0] q_cnt;
	logic tq_tick;
	logic seg_last;
	cbm_seg_t seg;
	cbm_seg_t next_seg;

	assign prop_len = {1'b0, cfg2[PROP_LSB +: SEG_W]} + ONE_TQ;
	assign ph1_len = {1'b0, cfg2[PH1_LSB +: SEG_W]} + ONE_TQ;
	assign ph2_prog = {1'b0, cfg2[PH2_LSB +: SEG_W]} + ONE_TQ;

	always_comb begin
		if (cfg2[PH2_SEL_BIT]) begin
			ph2_len = ph2_prog;
		end else if (ph1_len > IPT_TQ) begin
			ph2_len = ph1_len;
		end else begin
			ph2_len = IPT_TQ;
		end
	end

	always_comb begin
		case (seg)
			SEG_SYNC: begin
				seg_len = SYNC_TQ;
				next_seg = SEG_PROP;
			end
			SEG_PROP: begin
				seg_len = prop_len;
				next_seg = SEG_PH1;
			end
			SEG_PH1: begin
				seg_len = ph1_len;
				next_seg = SEG_PH2;
			end
			SEG_PH2: begin
				seg_len = ph2_len;
				next_seg = SEG_SYNC;
			end
			default: begin
				seg_len = SYNC_TQ;
				next_seg = SEG_SYNC;
			end
		endcase
	end

	assign tq_tick = tq_cnt == TQ_CNT_W'(TQ_CLKS - 1);
	assign seg_last = tq_tick && q_cnt == seg_len - ONE_TQ;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tq_cnt <= '0;
		end else if (tq_tick) begin
			tq_cnt <= '0;
		end else begin
			tq_cnt <= tq_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seg <= SEG_SYNC;
			q_cnt <= '0;
		end else if (seg_last) begin
			seg <= next_seg;
			q_cnt <= '0;
		end else if (tq_tick) begin
			q_cnt <= q_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_time_tq <= '0;
		end else begin
			bit_time_tq <= BT_W'(SYNC_TQ) + BT_W'(prop_len) + BT_W'(ph1_len) +
				BT_W'(ph2_len);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus sampling and wake-up filter.

	logic [2:0] rx_hist;
	logic rx_major;
	logic [TQ_CNT_W-1:0] wake_cnt;

	// History of the line at the last three quanta, the newest at bit 0.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_hist <= 3'h7;
		end else if (tq_tick) begin
			rx_hist <= {rx_hist[1:0], can_rx_i};
		end
	end

	assign rx_major = (rx_hist[0] & rx_hist[1]) | (rx_hist[0] & rx_hist[2]) |
		(rx_hist[1] & rx_hist[2]);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sample_point_o <= 1'b0;
			bit_start_o <= 1'b0;
			rx_bit_o <= 1'b1;
		end else begin
			sample_point_o <= seg_last && seg == SEG_PH1;
			bit_start_o <= seg_last && seg == SEG_PH2;
			if (seg_last && seg == SEG_PH1) begin
				rx_bit_o <= cfg2[SAM_BIT] ? rx_major : rx_hist[0];
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_cnt <= '0;
		end else if (can_rx_i) begin
			wake_cnt <= '0;
		end else if (wake_cnt != TQ_CNT_W'(WAKE_CLKS)) begin
			wake_cnt <= wake_cnt + 1'b1;
		end
	end

	// Without the filter any dominant level wakes; with it only a long one.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wakeup_o <= 1'b0;
		end else if (cfg2[WAKEUP_LINE_FILTER_ENABLE_BIT]) begin
			wakeup_o <= wake_cnt == TQ_CNT_W'(WAKE_CLKS);
		end else begin
			wakeup_o <= !can_rx_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Acceptance comparison for filters 8 to 15.

	logic [MSRC_W-1:0] msrc;
	logic [ID_W-1:0] id_mask;
	logic msel_ok;
	logic id_type_match_mode_sel;
	logic [ID_W-1:0] id_diff;
	logic id_ok;
	logic type_ok;

	assign msrc = fmsk[{filter_index_i, 1'b0} +: MSRC_W];

	always_comb begin
		msel_ok = 1'b1;
		id_mask = '0;
		id_type_match_mode_sel = 1'b0;
		case (msrc)
			MSRC_MASK0, MSRC_MASK1, MSRC_MASK2: begin
				id_mask = {mask_sid[msrc][SID_LSB +: SID_W],
					mask_sid[msrc][EIDHI_LSB +: EIDHI_W], mask_eid[msrc]};
				id_type_match_mode_sel = mask_sid[msrc][ID_TYPE_MATCH_MODE_BIT];
			end
			default: msel_ok = 1'b0;
		endcase
	end

	assign id_diff = (msg_id_i ^ filter_id_i) & id_mask;
	assign id_ok = msg_extended_i ? ~|id_diff : ~|id_diff[ID_W-1:MSG_SID_LSB];
	assign type_ok = !id_type_match_mode_sel || (msg_extended_i == filter_extended_enable_i);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			match_valid_o <= 1'b0;
			match_accept_o <= 1'b0;
		end else begin
			match_valid_o <= match_request_i;
			if (match_request_i) begin
				match_accept_o <= msel_ok && id_ok && type_ok;
			end
		end
	end

endmodule // cbm_bit_timing_mask

// *** verilog/cbm_pkg.sv ***
package cbm_pkg;

	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam int BE_W = 4;
	localparam int ID_W = 29;

	// Register byte offsets on the slave port.
	localparam logic [ADDR_W-1:0] OFF_INTF = 6'h00;
	localparam logic [ADDR_W-1:0] OFF_CFG2 = 6'h04;
	localparam logic [ADDR_W-1:0] OFF_FMSK = 6'h08;
	localparam logic [ADDR_W-1:0] OFF_MASK_BASE = 6'h0c;
	localparam logic [ADDR_W-1:0] MASK_STRIDE = 6'h08;
	localparam logic [ADDR_W-1:0] MASK_EID_OFS = 6'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h24;

	localparam int MASK_SETS = 3;
	localparam int UPPER_FILTERS = 8;
	localparam int FILT_IDX_W = 3;

	// Interrupt flag register.
	localparam int RX_FLAG_BIT = 1;
	localparam int TX_FLAG_BIT = 0;
	localparam logic [REG_W-1:0] INTF_RST = 16'h0000;

	// Bit timing configuration register.
	localparam int SEG_W = 3;
	localparam int PROP_LSB = 0;
	localparam int PH1_LSB = 3;
	localparam int SAM_BIT = 6;
	localparam int PH2_SEL_BIT = 7;
	localparam int PH2_LSB = 8;
	localparam int WAKEUP_LINE_FILTER_ENABLE_BIT = 14;
	localparam logic [REG_W-1:0] CFG2_WMASK = 16'h47ff;
	localparam logic [REG_W-1:0] CFG2_RST = 16'h0000;

	// Mask source selection register.
	localparam int MSRC_W = 2;
	localparam logic [MSRC_W-1:0] MSRC_MASK0 = 2'h0;
	localparam logic [MSRC_W-1:0] MSRC_MASK1 = 2'h1;
	localparam logic [MSRC_W-1:0] MSRC_MASK2 = 2'h2;
	localparam logic [REG_W-1:0] FMSK_RST = 16'h0000;

	// Standard identifier mask register.
	localparam int SID_LSB = 5;
	localparam int SID_W = 11;
	localparam int ID_TYPE_MATCH_MODE_BIT = 3;
	localparam int EIDHI_LSB = 0;
	localparam int EIDHI_W = 2;
	localparam int EIDLO_W = 16;
	localparam int MSG_SID_LSB = 18;
	localparam logic [REG_W-1:0] SID_WMASK = 16'hffeb;
	localparam logic [REG_W-1:0] MASK_RST = 16'h0000;

	// Timing.
	localparam int CLK_MHZ = 25;
	localparam int TQ_NS = 80;
	localparam int TQ_CLKS = (TQ_NS * CLK_MHZ) / 1000;
	localparam int WAKE_FILT_NS = 240;
	localparam int WAKE_CLKS = (WAKE_FILT_NS * CLK_MHZ + 999) / 1000;
	localparam int TQ_CNT_W = 4;
	localparam int LEN_W = 4;
	localparam int BT_W = 5;
	localparam logic [LEN_W-1:0] IPT_TQ = 4'h2;
	localparam logic [LEN_W-1:0] SYNC_TQ = 4'h1;
	localparam logic [LEN_W-1:0] ONE_TQ = 4'h1;

	typedef enum logic [1:0] {
		SEG_SYNC = 2'b00,
		SEG_PROP = 2'b01,
		SEG_PH1 = 2'b11,
		SEG_PH2 = 2'b10
	} cbm_seg_t;

endpackage
